// ===== rtl/fnvp_map.svh
// register offsets, field positions, reset values and sizes of the flash protection block
`ifndef FNVP_MAP_SVH
`define FNVP_MAP_SVH
`define FNVP_OFS_CMD 8'h00
`define FNVP_OFS_STAT 8'h04
`define FNVP_OFS_LOCK 8'h08
`define FNVP_OFS_NVBITS 8'h0C
`define FNVP_OFS_IRQ_STAT 8'h10
`define FNVP_OFS_IRQ_MASK 8'h14
`define FNVP_OFS_MODE 8'h18
`define FNVP_CMD_OP_LSB 0
`define FNVP_CMD_OP_MSB 3
`define FNVP_CMD_ARG_LSB 8
`define FNVP_CMD_ARG_MSB 17
`define FNVP_NREGION_MAX 16
`define FNVP_LOCK_W 16
`define FNVP_PAGE_W 10
`define FNVP_PPR_BIG 64
`define FNVP_PPR_SMALL 32
`define FNVP_SHIFT_BIG 6
`define FNVP_SHIFT_SMALL 5
`define FNVP_REGBITS 4
`define FNVP_EV_DONE 0
`define FNVP_EV_LOCKERR 1
`define FNVP_EV_CMDERR 2
`define FNVP_EV_PORTERR 3
`define FNVP_EV_W 4
`define FNVP_GP_BROWNOUT_EN 0
`define FNVP_GP_BROWNOUT_RST 1
`define FNVP_CAL_W 8
`define FNVP_CAL_DEFAULT 8'h5A
`define FNVP_OP_LATENCY 4'h3
`define FNVP_RESP_OKAY 2'b00
`define FNVP_RESP_SLVERR 2'b10
`endif

// ===== rtl/fnvp_pkg.sv
// types of the flash protection block
`default_nettype none
package fnvp_pkg;
  typedef enum logic [3:0] {
    FNVP_OP_NONE = 4'h0,
    FNVP_OP_PROGRAM = 4'h1,
    FNVP_OP_PAGE_ERASE = 4'h2,
    FNVP_OP_FULL_ERASE = 4'h3,
    FNVP_OP_SET_LOCK = 4'h4,
    FNVP_OP_CLR_LOCK = 4'h5,
    FNVP_OP_SET_GP = 4'h6,
    FNVP_OP_CLR_GP = 4'h7,
    FNVP_OP_SET_SEC = 4'h8
  } fnvp_op_t;
  typedef enum logic [2:0] {
    FNVP_IDLE = 3'b001,
    FNVP_BUSY = 3'b010,
    FNVP_DONE = 3'b100
  } fnvp_state_t;
  typedef struct packed {
    fnvp_op_t op;
    logic [9:0] arg;
  } fnvp_cmd_t;
  typedef struct packed {
    logic brownout_enable;
    logic brownout_reset_enable;
    logic [7:0] calibration;
  } fnvp_power_t;
  typedef struct packed {
    logic fast_prog_mode;
    logic boot_recovery;
  } fnvp_strap_t;
endpackage
`default_nettype wire

// ===== rtl/fnvp_top.sv
// flash protection and option bit manager with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "fnvp_map.svh"
module fnvp_top
  import fnvp_pkg::*;
#(
  parameter bit BIG_PAGES = 1'b1,
  parameter bit SIXTEEN_REGIONS = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // axi4-lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // pins and straps
  input wire logic i_erase_pin,
  input wire logic i_test_strap_pin,
  input wire logic i_port_line_0,
  input wire logic i_port_line_1,
  input wire logic i_port_line_2,
  // external port access requests
  input wire logic i_in_circuit_debug_port_req,
  input wire logic i_fast_programming_port_req,
  output logic o_in_circuit_debug_port_grant,
  output logic o_fast_programming_port_grant,
  // flash array and system outputs
  output logic o_flash_write_en,
  output logic o_flash_full_erase,
  output logic [9:0] o_flash_page,
  output fnvp_power_t o_power,
  output fnvp_strap_t o_strap,
  output logic o_irq
);
  localparam int unsigned SHIFT = BIG_PAGES ? `FNVP_SHIFT_BIG : `FNVP_SHIFT_SMALL;
  localparam logic [`FNVP_LOCK_W-1:0] REGION_MASK = SIXTEEN_REGIONS ? 16'hFFFF : 16'h00FF;

  // nonvolatile state, modelled as flops with a fixed reset image
  // limitation: a reset clears them, where the real bits outlive power loss
  logic [`FNVP_LOCK_W-1:0] lock_bits;
  wire logic [`FNVP_LOCK_W-1:0] next_lock_bits;
  logic security, next_security;
  logic [1:0] general_purpose_nv_bit, next_general_purpose_nv_bit;
  logic erase_seen, next_erase_seen;
  fnvp_state_t state, next_state;
  fnvp_cmd_t cmd, next_cmd;
  logic [3:0] busy_cnt, next_busy_cnt;
  logic [`FNVP_EV_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
  logic [`FNVP_EV_W-1:0] irq_w1c;
  fnvp_strap_t strap, next_strap;

  // bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  logic wr_fire;
  logic [`FNVP_REGBITS-1:0] region;
  logic locked;
  fnvp_op_t wop;
  logic set_lock_now, clr_lock_now;

  // a write needs address and data, held or live, and no answer still pending
  assign o_awready = !aw_held && !bvalid;
  assign o_wready = !w_held && !bvalid;
  assign o_arready = !rvalid;
  assign wr_fire = (aw_held || i_awvalid) && (w_held || i_wvalid) && !bvalid;

  // region selection from page number
  assign region = `FNVP_REGBITS'(cmd.arg >> SHIFT);
  assign locked = lock_bits[region] && REGION_MASK[region];

  // one update slice per lock region; the erase pin outranks a lock command ending in the same cycle
  assign set_lock_now = (state == FNVP_DONE) && (cmd.op == FNVP_OP_SET_LOCK);
  assign clr_lock_now = (state == FNVP_DONE) && (cmd.op == FNVP_OP_CLR_LOCK);
  for (genvar g = 0; g < `FNVP_NREGION_MAX; g++) begin : g_lock
    logic hit;
    assign hit = (region == `FNVP_REGBITS'(g));
    assign next_lock_bits[g] = i_erase_pin ? 1'b0 :
      (set_lock_now && hit) ? REGION_MASK[g] :
      (clr_lock_now && hit) ? 1'b0 : lock_bits[g];
  end

  always_comb begin
    logic [31:0] wd;
    logic [7:0] wa;
    wd = w_held ? w_data : i_wdata;
    wa = aw_held ? aw_addr : i_awaddr;

    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !i_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !i_rready;
    next_rdata = rdata;
    next_rresp = rresp;
    next_irq_mask = irq_mask;
    next_cmd = cmd;
    next_state = state;
    next_busy_cnt = busy_cnt;
    next_security = security;
    next_general_purpose_nv_bit = general_purpose_nv_bit;
    next_erase_seen = erase_seen;
    ev = '0;
    wop = fnvp_op_t'(wd[`FNVP_CMD_OP_MSB:`FNVP_CMD_OP_LSB]);
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `FNVP_RESP_OKAY;
      unique case (wa)
        `FNVP_OFS_CMD: begin
          // a command while one runs is refused and flagged
          if (state != FNVP_IDLE) begin
            ev[`FNVP_EV_CMDERR] = 1'b1;
          end else begin
            next_cmd.op = wop;
            next_cmd.arg = wd[`FNVP_CMD_ARG_MSB:`FNVP_CMD_ARG_LSB];
            // fixed latency stands in for the array's program and erase time
            next_busy_cnt = `FNVP_OP_LATENCY;
            next_state = FNVP_BUSY;
          end
        end
        `FNVP_OFS_IRQ_MASK: next_irq_mask = wd[`FNVP_EV_W-1:0];
        `FNVP_OFS_IRQ_STAT, `FNVP_OFS_STAT, `FNVP_OFS_LOCK, `FNVP_OFS_NVBITS, `FNVP_OFS_MODE: ;
        // an unmapped write is answered with an error and changes nothing
        default: next_bresp = `FNVP_RESP_SLVERR;
      endcase
    end

    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `FNVP_RESP_OKAY;
      unique case (i_araddr)
        `FNVP_OFS_CMD: next_rdata = {14'h0000, cmd.arg, 4'h0, cmd.op};
        `FNVP_OFS_STAT: next_rdata = {29'h0000_0000, security, state == FNVP_BUSY, state == FNVP_IDLE};
        `FNVP_OFS_LOCK: next_rdata = {16'h0000, lock_bits & REGION_MASK};
        `FNVP_OFS_NVBITS: next_rdata = {22'h00_0000, `FNVP_CAL_DEFAULT, general_purpose_nv_bit};
        `FNVP_OFS_IRQ_STAT: next_rdata = {28'h000_0000, irq_stat};
        `FNVP_OFS_IRQ_MASK: next_rdata = {28'h000_0000, irq_mask};
        `FNVP_OFS_MODE: next_rdata = {30'h0000_0000, strap};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `FNVP_RESP_SLVERR;
        end
      endcase
    end

    // command sequencer
    unique case (state)
      FNVP_IDLE: ;
      FNVP_BUSY: begin
        next_busy_cnt = busy_cnt - 4'h1;
        if (busy_cnt == 4'h1) begin
          next_state = FNVP_DONE;
        end
      end
      FNVP_DONE: begin
        next_state = FNVP_IDLE;
        ev[`FNVP_EV_DONE] = 1'b1;
        unique case (cmd.op)
          FNVP_OP_PROGRAM, FNVP_OP_PAGE_ERASE: begin
            if (locked) begin
              ev[`FNVP_EV_LOCKERR] = 1'b1;
            end
          end
          FNVP_OP_FULL_ERASE: begin
            if (|(lock_bits & REGION_MASK)) begin
              ev[`FNVP_EV_LOCKERR] = 1'b1;
            end else if (erase_seen) begin
              next_security = 1'b0;
              next_erase_seen = 1'b0;
            end
          end
          FNVP_OP_SET_LOCK, FNVP_OP_CLR_LOCK: ; // applied per region in g_lock
          FNVP_OP_SET_GP: next_general_purpose_nv_bit[cmd.arg[0]] = 1'b1;
          FNVP_OP_CLR_GP: next_general_purpose_nv_bit[cmd.arg[0]] = 1'b0;
          FNVP_OP_SET_SEC: begin
            // a wipe must come after the new protection before an erase can lift it
            next_security = 1'b1;
            next_erase_seen = 1'b0;
          end
          default: ev[`FNVP_EV_CMDERR] = 1'b1;
        endcase
      end
    endcase

    // erase pin wipes locks and general bits, never calibration; its length is the programmer's duty
    if (i_erase_pin) begin
      next_general_purpose_nv_bit = 2'b00;
      next_erase_seen = 1'b1;
    end

    // a refused port attempt while secured is logged as an event
    if (security && (i_in_circuit_debug_port_req || i_fast_programming_port_req)) begin
      ev[`FNVP_EV_PORTERR] = 1'b1;
    end
    irq_w1c = '0;
    if (wr_fire && wa == `FNVP_OFS_IRQ_STAT && w_strb_or(w_held, w_strb, i_wstrb)) begin
      irq_w1c = wd[`FNVP_EV_W-1:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_stat = (irq_stat & ~irq_w1c) | ev;
  end

  function automatic logic w_strb_or(input logic held, input logic [3:0] hs, input logic [3:0] is);
    w_strb_or = held ? hs[0] : is[0];
  endfunction

  // straps are caught every cycle after reset, since they are levels the programmer holds
  always_comb begin
    next_strap.fast_prog_mode = i_test_strap_pin && i_port_line_0 && i_port_line_1 && !i_port_line_2;
    next_strap.boot_recovery = i_test_strap_pin && i_port_line_0 && i_port_line_1 && i_port_line_2;
  end

  // bus channel registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `FNVP_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `FNVP_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // command sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cmd <= '0;
      state <= FNVP_IDLE;
      busy_cnt <= 4'h0;
    end else begin
      cmd <= next_cmd;
      state <= next_state;
      busy_cnt <= next_busy_cnt;
    end
  end

  // protection and option bits
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lock_bits <= '0;
      security <= 1'b0;
      general_purpose_nv_bit <= 2'b00;
      erase_seen <= 1'b0;
    end else begin
      lock_bits <= next_lock_bits;
      security <= next_security;
      general_purpose_nv_bit <= next_general_purpose_nv_bit;
      erase_seen <= next_erase_seen;
    end
  end

  // interrupt status and mask
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // strap capture
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      strap <= '0;
    end else begin
      strap <= next_strap;
    end
  end

  // array strobes only for commands that pass the lock check, so a locked page is never touched
  always_comb begin
    o_flash_write_en = (state == FNVP_DONE) && !locked &&
      (cmd.op == FNVP_OP_PROGRAM || cmd.op == FNVP_OP_PAGE_ERASE);
    o_flash_full_erase = (state == FNVP_DONE) && (cmd.op == FNVP_OP_FULL_ERASE) && !(|(lock_bits & REGION_MASK));
  end

  assign o_flash_page = cmd.arg;
  assign o_in_circuit_debug_port_grant = i_in_circuit_debug_port_req && !security;
  assign o_fast_programming_port_grant = i_fast_programming_port_req && !security && strap.fast_prog_mode;

  // option bits and straps toward the system
  assign o_power.brownout_enable = general_purpose_nv_bit[`FNVP_GP_BROWNOUT_EN];
  assign o_power.brownout_reset_enable = general_purpose_nv_bit[`FNVP_GP_BROWNOUT_RST];
  assign o_power.calibration = `FNVP_CAL_DEFAULT;
  assign o_strap = strap;

  // bus answers
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_irq = |(irq_stat & irq_mask);
endmodule // fnvp_top
`default_nettype wire

// ===== verif/fnvp_top_asserts.sv
// port-level assertions for the flash protection block
`timescale 1ns/1ps
`default_nettype none
`include "fnvp_map.svh"
module fnvp_top_asserts
  import fnvp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // pins and port requests
  input wire logic i_erase_pin,
  input wire logic i_test_strap_pin,
  input wire logic i_port_line_0,
  input wire logic i_port_line_1,
  input wire logic i_port_line_2,
  input wire logic i_in_circuit_debug_port_req,
  input wire logic i_fast_programming_port_req,
  // device outputs
  input wire logic o_in_circuit_debug_port_grant,
  input wire logic o_fast_programming_port_grant,
  input wire logic o_flash_write_en,
  input wire logic o_flash_full_erase,
  input wire fnvp_power_t o_power,
  input wire fnvp_strap_t o_strap
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_tp; i_test_strap_pin && i_port_line_0 && i_port_line_1; endsequence
  sequence s_fast; s_tp ##0 !i_port_line_2; endsequence
  sequence s_boot; s_tp ##0 i_port_line_2; endsequence
  property p_fast; s_fast |=> o_strap.fast_prog_mode && !o_strap.boot_recovery; endproperty
  a_fast: assert property (p_fast) else $error("fast mode strap missed");
  property p_boot; s_boot |=> o_strap.boot_recovery && !o_strap.fast_prog_mode; endproperty
  a_boot: assert property (p_boot) else $error("boot recovery strap missed");
  property p_fgnt; o_fast_programming_port_grant |-> i_fast_programming_port_req && o_strap.fast_prog_mode; endproperty
  a_fgnt: assert property (p_fgnt) else $error("fast port grant without cause");
  property p_dgnt; o_in_circuit_debug_port_grant |-> i_in_circuit_debug_port_req; endproperty
  a_dgnt: assert property (p_dgnt) else $error("debug grant without request");
  property p_cal; o_power.calibration == `FNVP_CAL_DEFAULT; endproperty
  a_cal: assert property (p_cal) else $error("calibration bits changed");
  property p_wipe; i_erase_pin |=> !o_power.brownout_enable && !o_power.brownout_reset_enable; endproperty
  a_wipe: assert property (p_wipe) else $error("general bits survive wipe");
  property p_wen; o_flash_write_en |=> !o_flash_write_en; endproperty
  a_wen: assert property (p_wen) else $error("write strobe too long");
  property p_fer; o_flash_full_erase |-> !o_flash_write_en ##1 !o_flash_full_erase; endproperty
  a_fer: assert property (p_fer) else $error("full erase strobe wrong");
endmodule // fnvp_top_asserts
bind fnvp_top fnvp_top_asserts chk_u (.*);
`default_nettype wire

// ===== verif/fnvp_prog_model.sv
// external programmer model: straps, wipe pin and port requests
`timescale 1ns/1ps
`default_nettype none
module fnvp_prog_model (
  // clock and action: 1 fast prog, 2 boot recovery, 3 wipe
  input wire logic i_clk,
  input wire logic [1:0] i_act,
  // pins toward the device
  output logic o_erase_pin,
  output logic o_test_strap_pin,
  output logic [2:0] o_port_line,
  output logic o_dbg_req,
  output logic o_fpp_req
);
  initial {o_erase_pin, o_test_strap_pin, o_port_line, o_dbg_req, o_fpp_req} = 7'h0;
  // wipe length is whatever the bench holds the action for
  always @(posedge i_clk) begin
    o_erase_pin <= i_act == 2'h3;
    o_test_strap_pin <= i_act == 2'h1 || i_act == 2'h2;
    o_port_line <= i_act == 2'h1 ? 3'h3 : i_act == 2'h2 ? 3'h7 : 3'h0;
    o_dbg_req <= i_act == 2'h1;
    o_fpp_req <= i_act == 2'h1;
  end
endmodule // fnvp_prog_model
`default_nettype wire

// ===== verif/fnvp_top_tb.sv
// self-checking bench for the flash protection block
`timescale 1ns/1ps
`default_nettype none
`include "fnvp_map.svh"
module fnvp_top_tb;
  import fnvp_pkg::*;
  // short stand-in for the long wipe hold
  localparam int WIPE_CYC = 20;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] CALV = 32'(`FNVP_CAL_DEFAULT) << 2;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] act = 2'h0, o_bresp, o_rresp, r;
  logic [2:0] pl;
  logic i_erase_pin, i_test_strap_pin, i_in_circuit_debug_port_req, i_fast_programming_port_req;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_flash_write_en, o_flash_full_erase;
  logic o_in_circuit_debug_port_grant, o_fast_programming_port_grant;
  logic [9:0] o_flash_page;
  fnvp_power_t o_power;
  fnvp_strap_t o_strap;
  wire i_port_line_0 = pl[0];
  wire i_port_line_1 = pl[1];
  wire i_port_line_2 = pl[2];
  int error_cnt = 0, n_checks = 0, n_wen = 0, n_fer = 0;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_wen += o_flash_write_en;
    n_fer += o_flash_full_erase;
  end
  fnvp_top dut_u (.*);
  fnvp_prog_model prog_u (.i_clk(i_clk), .i_act(act), .o_erase_pin(i_erase_pin),
    .o_test_strap_pin(i_test_strap_pin), .o_port_line(pl),
    .o_dbg_req(i_in_circuit_debug_port_req), .o_fpp_req(i_fast_programming_port_req));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // readies are sampled mid-cycle so the handshake edge is known before it comes
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= v;
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    for (int n = 0; n < 30; n++) begin
      @(negedge i_clk);
      ha = i_awvalid && o_awready;
      hw = i_wvalid && o_wready;
      hb = o_bvalid;
      r = o_bresp;
      @(posedge i_clk);
      if (ha) i_awvalid <= 1'b0;
      if (hw) i_wvalid <= 1'b0;
      if (hb) begin
        i_bready <= 1'b0;
        return;
      end
    end
    $display("[ERR] %0t write answer timeout", $time);
    error_cnt++;
    tally_and_finish;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge i_clk);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'h3;
    for (int n = 0; n < 30; n++) begin
      @(negedge i_clk);
      ha = i_arvalid && o_arready;
      hr = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (ha) i_arvalid <= 1'b0;
      if (hr) begin
        i_rready <= 1'b0;
        return;
      end
    end
    $display("[ERR] %0t read answer timeout", $time);
    error_cnt++;
    tally_and_finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  // a command runs four cycles; six leaves it idle before the next
  task automatic cmd(input logic [3:0] op, input logic [9:0] pg);
    wr(`FNVP_OFS_CMD, {14'h0, pg, 4'h0, op});
    repeat (6) @(posedge i_clk);
  endtask
  task automatic pins(input logic [1:0] a, input int n);
    act <= a;
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rchk(`FNVP_OFS_LOCK, ALL, 32'h0);
    rchk(`FNVP_OFS_NVBITS, ALL, CALV);
    rchk(`FNVP_OFS_STAT, 32'h7, 32'h1);
    rd(8'h1C);
    chk(r, `FNVP_RESP_SLVERR);
    wr(8'h1C, 32'h0);
    chk(r, `FNVP_RESP_SLVERR);
    $display("reset test done");
    wr(`FNVP_OFS_IRQ_MASK, 32'hF);
    cmd(FNVP_OP_SET_LOCK, 10'd64);
    rchk(`FNVP_OFS_LOCK, ALL, 32'h2);
    cmd(FNVP_OP_PROGRAM, 10'd63);
    chk(o_flash_page, 32'd63);
    cmd(FNVP_OP_PAGE_ERASE, 10'd64);
    cmd(FNVP_OP_FULL_ERASE, 10'd0);
    chk(n_wen, 1);
    chk(n_fer, 0);
    rchk(`FNVP_OFS_IRQ_STAT, 32'h3, 32'h3);
    chk(o_irq, 1'b1);
    cmd(4'hF, 10'd0);
    rchk(`FNVP_OFS_IRQ_STAT, 32'h4, 32'h4);
    wr(`FNVP_OFS_IRQ_STAT, 32'hF);
    @(negedge i_clk);
    chk(o_irq, 1'b0);
    cmd(FNVP_OP_CLR_LOCK, 10'd64);
    rchk(`FNVP_OFS_LOCK, ALL, 32'h0);
    $display("lock test done");
    cmd(FNVP_OP_SET_GP, 10'd0);
    cmd(FNVP_OP_SET_GP, 10'd1);
    cmd(FNVP_OP_SET_LOCK, 10'd0);
    chk({o_power.brownout_enable, o_power.brownout_reset_enable}, 32'h3);
    cmd(FNVP_OP_CLR_GP, 10'd1);
    rchk(`FNVP_OFS_NVBITS, 32'h3, 32'h1);
    cmd(FNVP_OP_SET_GP, 10'd1);
    wr(`FNVP_OFS_CMD, {14'h0, 10'd1, 4'h0, FNVP_OP_SET_GP});
    cmd(FNVP_OP_CLR_GP, 10'd0);
    rchk(`FNVP_OFS_NVBITS, 32'h3, 32'h3);
    rchk(`FNVP_OFS_IRQ_STAT, 32'h4, 32'h4);
    pins(2'h3, WIPE_CYC);
    pins(2'h0, 3);
    rchk(`FNVP_OFS_LOCK, ALL, 32'h0);
    rchk(`FNVP_OFS_NVBITS, ALL, CALV);
    chk(o_power.calibration, `FNVP_CAL_DEFAULT);
    $display("option bit test done");
    cmd(FNVP_OP_SET_SEC, 10'd0);
    rchk(`FNVP_OFS_STAT, 32'h4, 32'h4);
    cmd(FNVP_OP_FULL_ERASE, 10'd0);
    rchk(`FNVP_OFS_STAT, 32'h4, 32'h4);
    pins(2'h1, 3);
    chk({o_in_circuit_debug_port_grant, o_fast_programming_port_grant}, 32'h0);
    chk(o_strap, 2'h2);
    rchk(`FNVP_OFS_IRQ_STAT, 32'h8, 32'h8);
    pins(2'h3, WIPE_CYC);
    pins(2'h0, 3);
    rchk(`FNVP_OFS_STAT, 32'h4, 32'h4);
    cmd(FNVP_OP_FULL_ERASE, 10'd0);
    rchk(`FNVP_OFS_STAT, 32'h4, 32'h0);
    chk(n_fer, 2);
    pins(2'h1, 3);
    chk({o_in_circuit_debug_port_grant, o_fast_programming_port_grant}, 32'h3);
    pins(2'h2, 3);
    chk(o_strap, 2'h1);
    $display("security and strap test done");
    tally_and_finish;
  end
endmodule // fnvp_top_tb
`default_nettype wire
